// ==== hdl/lcc_ctrl.sv ====
// Purpose: Charge sequencer of a single-cell linear charger
// Assumes: Analog comparators arrive asynchronously as levels
// Notes: Variant straps are parameters; registers over classic Wishbone
// Operation
// RULE1 - Input foldback limits pass current
// RULE2 - Programming resistor short latches off
// RULE3 - Open pin: ten percent termination
// RULE4 - Precharge is always twice termination
// RULE5 - Precharge below 2.5 V, then fast
// RULE6 - Normal zone charges at full settings
// RULE7 - Cold zone halves charge current
// RULE8 - Warm zone lowers regulation voltage
// RULE9 - Reduced variant stops above 45 C
// RULE10 - Above 60 or below 0 disables
// RULE11 - Pin low disables, high enters TIMER_TERMINATION_DISABLE_MODE
// RULE12 - Thirty minute precharge safety timer
// RULE13 - Ten hour fast-charge safety timer
// RULE14 - Timers half rate under regulation
// RULE15 - Timer expiry terminates, releases indicator
// RULE16 - Timer reset on disable, power, TIMER_TERMINATION_DISABLE_MODE
// RULE17 - Taper at regulation runs battery detect
// RULE18 - Missing battery repeats detection
// RULE19 - Below lockout everything high impedance
// RULE20 - Power-up resets, qualifies, starts timer
// RULE21 - Sleep stops current, pauses timer
// RULE22 - Listed events start new cycle
// RULE23 - TIMER_TERMINATION_DISABLE_MODE holds timer, suppresses termination
// RULE24 - Recharge below threshold after termination
// RULE25 - Raised termination during first minute
// RULE26 - Junction limit sets thermal regulation
// RULE27 - One gated tick counter drives timers
//
// Chosen here: the address map and the Wishbone register port.
module lcc_ctrl import lcc_pkg::*; #(
  parameter bit REDUCED_ZONE = 1'b0,
  parameter bit HIGH_V = 1'b0,
  parameter bit INDICATOR = 1'b1,
  parameter logic [31:0] TICK_CYC_P = TICK_CYC,
  parameter logic [SEC_W-1:0] PRE_S_P = SEC_W'(PRE_TIMER_S),
  parameter logic [SEC_W-1:0] FAST_S_P = SEC_W'(FAST_TIMER_S),
  parameter logic [SEC_W-1:0] BOOST_S_P = SEC_W'(BOOST_S)
) (
  input wire logic core_clk_in, // Core clock
  input wire logic rst_in, // Synchronous reset
  input wire logic uvlo_ok_in, // Input above lockout
  input wire logic in_gt_out_in, // Input above output plus offset
  input wire logic ovp_in, // Input overvoltage
  input wire logic input_voltage_foldback_in, // At foldback_voltage_threshold
  input wire logic thermal_reg_in, // Junction at regulation limit
  input wire logic fast_current_program_pin_short_in, // fast_current_program_pin reads short
  input wire logic cur_ge_50_in, // Output current at least 50 mA
  input wire logic lowv_ok_in, // Battery at or above 2.5 V
  input wire logic above_rch_in, // Output above recharge_threshold
  input wire logic at_term_in, // Current tapered to termination
  input wire logic batt_present_in, // Battery detect result
  input wire logic ts_low_in, // thermistor_sense_pin pulled low
  input wire logic ts_high_in, // thermistor_sense_pin high or open
  input wire logic below0_in, // Battery below 0 C
  input wire logic below10_in, // Battery below 10 C
  input wire logic above45_in, // Battery above 45 C
  input wire logic above60_in, // Battery above 60 C
  input wire logic preterm_open_in, // Programming pin left open
  input wire logic [6:0] preterm_pct_in, // Programmed termination percent
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic charge_en_out, // Pass device enabled
  output logic qual_charge_out, // 22 mA qualification current
  output logic halve_current_out, // Half programmed current
  output logic [12:0] vreg_limit_mv_out, // Warm regulation cap, 0 full
  output logic [6:0] term_pct_out, // Termination percent
  output logic [7:0] pre_pct_out, // Precharge percent
  output logic foldback_limit_out, // Foldback current reduction
  output logic thermal_limit_out, // Thermal current reduction
  output logic charge_indicator_output_oe_out, // Indicator pulls low
  output logic power_good_out, // Power good
  output logic hiz_out, // All pins high impedance
  output logic batt_detect_out, // Battery detect running
  output logic term_boost_out, // Termination threshold raised
  output logic [3:0] phase_out // Sequencer state
);
  typedef struct packed {
    lcc_pins_t s1;
    lcc_pins_t s2;
    lcc_state_t st;
    lcc_state_t resume;
    logic timer_termination_disable_mode;
    logic absent_seen;
    logic first;
    logic [11:0] cnt;
    logic inhibit;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic charge_en;
    logic qual;
    logic halve;
    logic [12:0] vreg_mv;
    logic [6:0] term_pct;
    logic [7:0] pre_pct;
    logic fold_lim;
    logic therm_lim;
    logic ind_oe;
    logic pg;
    logic hiz;
    logic detect;
    logic boost;
  } lcc_ctrl_t;
  lcc_ctrl_t r;
  lcc_ctrl_t n;
  lcc_pins_t pins;
  lcc_pins_t p;
  logic temp_fault;
  logic charging;
  logic timing;
  logic short_hit;
  logic disable_req;
  logic new_cyc;
  logic wb_req;
  logic [6:0] term_sel;

  lcc_tmr_if tmr ();

  lcc_timer #(
    .TICK_CYC_P(TICK_CYC_P),
    .PRE_S_P(PRE_S_P),
    .FAST_S_P(FAST_S_P),
    .BOOST_S_P(BOOST_S_P)
  ) u_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .tmr(tmr)
  );

  // Pin bundle; every level passes two flops before use
  assign pins = '{uvlo_ok: uvlo_ok_in, in_gt_out: in_gt_out_in, ovp: ovp_in,
    foldback: input_voltage_foldback_in, thermal_reg: thermal_reg_in,
    fast_current_program_pin_short: fast_current_program_pin_short_in, cur_ge_50: cur_ge_50_in, lowv_ok: lowv_ok_in,
    above_rch: above_rch_in, at_term: at_term_in, batt_present: batt_present_in,
    ts_low: ts_low_in, ts_high: ts_high_in, below0: below0_in, below10: below10_in,
    above45: above45_in, above60: above60_in, preterm_open: preterm_open_in,
    preterm_pct: preterm_pct_in};
  assign p = r.s2;

  // Derived conditions from synchronised levels and state
  assign temp_fault = p.below0 | p.above60 | (REDUCED_ZONE & p.above45); // RULE10 RULE9
  assign disable_req = p.ts_low | r.inhibit; // RULE11
  assign charging = r.st inside {ST_QUAL, ST_PRE, ST_FAST, ST_CV, ST_DETECT};
  assign timing = r.st inside {ST_PRE, ST_FAST, ST_CV, ST_DETECT};
  assign short_hit = charging & p.fast_current_program_pin_short & p.cur_ge_50; // RULE2
  assign term_sel = p.preterm_open ? TERM_DEF_PCT : p.preterm_pct; // RULE3
  assign wb_req = wb_cyc_i & wb_stb_i;

  // Timer steering; clear in off, qualification, disabled and short states or in TIMER_TERMINATION_DISABLE_MODE
  assign tmr.clear = (r.st inside {ST_OFF, ST_QUAL, ST_DISABLED, ST_SHORT}) | r.timer_termination_disable_mode; // RULE16 RULE23
  assign tmr.run = timing & ~p.ovp & ~temp_fault & p.in_gt_out; // RULE27 RULE21
  assign tmr.half = p.foldback | p.thermal_reg; // RULE14 RULE26

  // Sequencer, output and register next state
  always_comb begin
    n = r;
    new_cyc = 1'b0;
    n.s1 = pins;
    n.s2 = r.s1;
    n.timer_termination_disable_mode = p.ts_high & p.uvlo_ok; // RULE11
    if (!p.uvlo_ok) begin
      n.st = ST_OFF; // RULE19
      n.first = 1'b0;
      n.absent_seen = 1'b0;
    end else if (r.st == ST_OFF) begin
      new_cyc = 1'b1; // RULE20 RULE22
    end else if (short_hit) begin
      n.st = ST_SHORT; // RULE2
    end else if (disable_req) begin
      n.st = ST_DISABLED; // RULE11
    end else if (r.st == ST_SHORT) begin
      n.st = ST_SHORT; // RULE2
    end else if (r.st == ST_DISABLED) begin
      new_cyc = 1'b1; // RULE22
    end else if (r.st == ST_SLEEP) begin
      if (p.in_gt_out) begin
        n.st = r.resume; // RULE21
      end
    end else if (!p.in_gt_out) begin
      n.resume = r.st; // RULE21
      n.st = ST_SLEEP;
    end else if (r.timer_termination_disable_mode && !p.ts_high) begin
      new_cyc = 1'b1; // RULE22
    end else begin
      case (r.st)
        ST_QUAL: begin
          n.cnt = r.cnt + 12'h001;
          if (r.cnt == QUAL_CYC - 12'h001) begin
            n.st = p.lowv_ok ? ST_FAST : ST_PRE; // RULE20 RULE5
          end
        end
        ST_PRE: begin
          if (tmr.pre_exp && !r.timer_termination_disable_mode) begin
            n.st = ST_TIMEOUT; // RULE12 RULE15
          end else if (p.lowv_ok) begin
            n.st = ST_FAST; // RULE5
          end
        end
        ST_FAST: begin
          if (tmr.fast_exp && !r.timer_termination_disable_mode) begin
            n.st = ST_TIMEOUT; // RULE13 RULE15
          end else if (p.above_rch) begin
            n.st = ST_CV;
          end
        end
        ST_CV: begin
          if (tmr.fast_exp && !r.timer_termination_disable_mode) begin
            n.st = ST_TIMEOUT; // RULE15
          end else if (p.at_term && !r.timer_termination_disable_mode) begin
            n.st = ST_DETECT; // RULE17 RULE23
            n.cnt = '0;
          end
        end
        ST_DETECT: begin
          n.cnt = r.cnt + 12'h001;
          if (r.timer_termination_disable_mode) begin
            n.st = ST_CV; // RULE17
          end else if (r.cnt == DET_CYC - 12'h001) begin
            n.cnt = '0;
            if (!p.batt_present) begin
              n.absent_seen = 1'b1; // RULE18
              n.first = 1'b0;
            end else if (r.absent_seen) begin
              new_cyc = 1'b1; // RULE22
            end else begin
              n.st = ST_DONE; // RULE17
              n.first = 1'b0;
            end
          end
        end
        ST_DONE: begin
          if (!p.above_rch) begin
            new_cyc = 1'b1; // RULE24
          end
        end
        ST_TIMEOUT: n.first = 1'b0; // RULE15
        default: n.st = ST_OFF;
      endcase
    end
    // Restart after any trigger; timer stays clear through qualification
    if (new_cyc) begin
      n.st = ST_QUAL;
      n.cnt = '0;
      n.first = 1'b1;
      n.absent_seen = 1'b0;
    end
    // Registered outputs; one cycle behind the state
    n.charge_en = charging & ~temp_fault & ~p.ovp; // RULE6 RULE10 RULE21
    n.qual = (r.st == ST_QUAL) & ~p.ovp; // RULE20
    n.halve = p.below10 & ~p.below0; // RULE7 RULE9
    n.vreg_mv = VREG_FULL;
    if (p.above45 && !p.above60 && !REDUCED_ZONE) begin
      n.vreg_mv = HIGH_V ? WARM_VREG_HV_MV : WARM_VREG_STD_MV; // RULE8
    end
    n.term_pct = term_sel; // RULE3
    n.pre_pct = {term_sel, 1'b0}; // RULE4
    n.fold_lim = p.foldback & charging; // RULE1
    n.therm_lim = p.thermal_reg & charging; // RULE26
    // Indicator dark in sleep and overvoltage but remembers first charge
    n.ind_oe = INDICATOR & r.first & p.uvlo_ok & p.in_gt_out & ~p.ovp; // RULE15
    n.pg = p.uvlo_ok & p.in_gt_out & ~p.ovp; // RULE20
    n.hiz = ~p.uvlo_ok; // RULE19
    n.detect = r.st == ST_DETECT; // RULE17
    n.boost = charging & tmr.boost & ~r.timer_termination_disable_mode; // RULE25
    // Wishbone: ack one cycle after request, write commits on the ack edge
    n.wb_ack = wb_req & ~r.wb_ack;
    if (wb_req && r.wb_ack && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
      n.inhibit = wb_dat_i[CTRL_INHIBIT_BIT];
    end
    if (wb_req && !r.wb_ack) begin
      n.wb_dat = '0;
      case (wb_adr_i)
        ADDR_CTRL: n.wb_dat[CTRL_INHIBIT_BIT] = r.inhibit;
        ADDR_STAT: begin
          n.wb_dat[STAT_STATE_LSB +: 4] = r.st;
          n.wb_dat[STAT_TIMER_TERMINATION_DISABLE_MODE_BIT] = r.timer_termination_disable_mode;
          n.wb_dat[STAT_TEMPF_BIT] = temp_fault;
          n.wb_dat[STAT_PG_BIT] = r.pg;
          n.wb_dat[STAT_FIRST_BIT] = r.first;
          n.wb_dat[STAT_ABSENT_BIT] = r.absent_seen;
        end
        ADDR_TIME: n.wb_dat[SEC_W-1:0] = tmr.secs;
        default: n.wb_dat = '0;
      endcase
    end
  end

  // Whole state in one register; reset holds the pins dark
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r <= '0;
      r.inhibit <= CTRL_INHIBIT_RST;
      r.hiz <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign wb_ack_o = r.wb_ack;
  assign wb_dat_o = r.wb_dat;
  assign charge_en_out = r.charge_en;
  assign qual_charge_out = r.qual;
  assign halve_current_out = r.halve;
  assign vreg_limit_mv_out = r.vreg_mv;
  assign term_pct_out = r.term_pct;
  assign pre_pct_out = r.pre_pct;
  assign foldback_limit_out = r.fold_lim;
  assign thermal_limit_out = r.therm_lim;
  assign charge_indicator_output_oe_out = r.ind_oe;
  assign power_good_out = r.pg;
  assign hiz_out = r.hiz;
  assign batt_detect_out = r.detect;
  assign term_boost_out = r.boost;
  assign phase_out = r.st;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  short_latch_a: assert property (p.uvlo_ok && short_hit |=> r.st == ST_SHORT) // RULE2
    else $error("short not latched");
  short_hold_a: assert property (r.st == ST_SHORT && p.uvlo_ok && !disable_req
    |=> r.st == ST_SHORT) // RULE2
    else $error("short latch released");
  term_pair_a: assert property (p.preterm_open |=> term_pct_out == 7'h0A
    && pre_pct_out == 8'h14) // RULE3
    else $error("open pin defaults wrong");
  pre_double_a: assert property (pre_pct_out == {term_pct_out, 1'b0}) // RULE4
    else $error("precharge not twice termination");
  lowv_fast_a: assert property (r.st == ST_PRE && p.lowv_ok && p.uvlo_ok && p.in_gt_out
    && !disable_req && !short_hit && !tmr.pre_exp && !(r.timer_termination_disable_mode && !p.ts_high)
    |=> r.st == ST_FAST) // RULE5
    else $error("no fast charge at 2.5 V");
  cold_half_a: assert property (p.below10 && !p.below0 |=> halve_current_out) // RULE7
    else $error("cold zone not halved");
  temp_off_a: assert property (temp_fault |=> !charge_en_out) // RULE10
    else $error("charging outside temperature range");
  ts_low_a: assert property (p.uvlo_ok && p.ts_low && !short_hit && r.st != ST_OFF
    |=> r.st == ST_DISABLED) // RULE11
    else $error("pin low did not disable");
  sleep_pause_a: assert property (r.st == ST_SLEEP |-> !tmr.run ##1 !charge_en_out) // RULE21
    else $error("charging in sleep");
  half_rate_a: assert property (p.thermal_reg && charging |-> tmr.half ##1 thermal_limit_out) // RULE14
    else $error("half rate not applied");
  lockout_a: assert property (!p.uvlo_ok
    |=> hiz_out && !power_good_out && r.st == ST_OFF) // RULE19
    else $error("pins active below lockout");
  pre_timeout_a: assert property (r.st == ST_PRE && tmr.pre_exp && !r.timer_termination_disable_mode && p.uvlo_ok
    && p.in_gt_out && !disable_req && !short_hit && !(r.timer_termination_disable_mode && !p.ts_high)
    |=> r.st == ST_TIMEOUT) // RULE12
    else $error("precharge timer expiry ignored");
endmodule

// ==== hdl/lcc_pkg.sv ====
// Purpose: Shared constants and types for the linear charge sequencer
// Assumes: 200 MHz core clock; analog comparators report as digital levels
// Notes: Timer figures are kept in their own units and converted here
package lcc_pkg;
  // Clock and timebase
  localparam int CLK_MHZ = 200;
  localparam int TICK_MS = 1000;
  localparam int TICK_CYC = TICK_MS * 1000 * CLK_MHZ;
  // Safety timers, counted in timebase ticks (seconds)
  localparam int PRE_TIMER_MIN = 30;
  localparam int PRE_TIMER_S = PRE_TIMER_MIN * 60;
  localparam int FAST_TIMER_HR = 10;
  localparam int FAST_TIMER_S = FAST_TIMER_HR * 3600;
  localparam int BOOST_MIN = 1;
  localparam int BOOST_S = BOOST_MIN * 60;
  localparam int SEC_W = 17;
  // Qualification charge and battery-detect settle windows
  localparam int QUAL_US = 10;
  localparam logic [11:0] QUAL_CYC = 12'(QUAL_US * CLK_MHZ);
  localparam int DET_US = 5;
  localparam logic [11:0] DET_CYC = 12'(DET_US * CLK_MHZ);
  // Pre-charge and termination defaults for an open programming pin
  localparam logic [6:0] TERM_DEF_PCT = 7'h0A;
  // Warm-zone regulation limits in mV, zero means full regulation
  localparam logic [12:0] WARM_VREG_STD_MV = 13'h1004;
  localparam logic [12:0] WARM_VREG_HV_MV = 13'h1068;
  localparam logic [12:0] VREG_FULL = 13'h0000;
  // Wishbone register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_TIME = 8'h08;
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam logic CTRL_INHIBIT_RST = 1'b0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_TIMER_TERMINATION_DISABLE_MODE_BIT = 4;
  localparam int STAT_TEMPF_BIT = 5;
  localparam int STAT_PG_BIT = 6;
  localparam int STAT_FIRST_BIT = 7;
  localparam int STAT_ABSENT_BIT = 8;

  typedef enum logic [3:0] {
    ST_OFF, ST_QUAL, ST_PRE, ST_FAST, ST_CV, ST_DETECT, ST_DONE,
    ST_TIMEOUT, ST_SHORT, ST_DISABLED, ST_SLEEP
  } lcc_state_t;

  // Comparator levels arriving from the analog side
  typedef struct packed {
    logic uvlo_ok;
    logic in_gt_out;
    logic ovp;
    logic foldback;
    logic thermal_reg;
    logic fast_current_program_pin_short;
    logic cur_ge_50;
    logic lowv_ok;
    logic above_rch;
    logic at_term;
    logic batt_present;
    logic ts_low;
    logic ts_high;
    logic below0;
    logic below10;
    logic above45;
    logic above60;
    logic preterm_open;
    logic [6:0] preterm_pct;
  } lcc_pins_t;
endpackage

// ==== hdl/lcc_timer.sv ====
// Purpose: Single tick counter behind both safety timers and the boost minute
// Assumes: Clear has priority over run
// Notes: Half rate skips every other tick rather than stretching the prescaler
module lcc_timer import lcc_pkg::*; #(
  parameter logic [31:0] TICK_CYC_P = TICK_CYC,
  parameter logic [SEC_W-1:0] PRE_S_P = SEC_W'(PRE_TIMER_S),
  parameter logic [SEC_W-1:0] FAST_S_P = SEC_W'(FAST_TIMER_S),
  parameter logic [SEC_W-1:0] BOOST_S_P = SEC_W'(BOOST_S)
) (
  input wire logic core_clk_in, // Core clock
  input wire logic rst_in, // Synchronous reset
  lcc_tmr_if.timer tmr // Sequencer link
);
  typedef struct packed {
    logic [31:0] presc;
    logic slow;
    logic [SEC_W-1:0] secs;
    logic pre_exp;
    logic fast_exp;
    logic boost;
  } lcc_tmr_t;
  lcc_tmr_t r;
  lcc_tmr_t n;

  // Prescaler, half-rate gate and saturating seconds
  always_comb begin
    n = r;
    if (tmr.clear) begin
      n.presc = '0; // RULE16
      n.slow = 1'b0;
      n.secs = '0;
    end else if (tmr.run) begin // RULE27
      if (r.presc == TICK_CYC_P - 32'h1) begin
        n.presc = '0;
        n.slow = tmr.half ? ~r.slow : 1'b0;
        if ((!tmr.half || r.slow) && r.secs != FAST_S_P) begin // RULE14
          n.secs = r.secs + SEC_W'(1);
        end
      end else begin
        n.presc = r.presc + 32'h1;
      end
    end
    n.pre_exp = r.secs >= PRE_S_P; // RULE12
    n.fast_exp = r.secs >= FAST_S_P; // RULE13
    n.boost = r.secs < BOOST_S_P; // RULE25
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tmr.pre_exp = r.pre_exp;
  assign tmr.fast_exp = r.fast_exp;
  assign tmr.boost = r.boost;
  assign tmr.secs = r.secs;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  secs_paused_a: assert property (!tmr.clear && !tmr.run |=> $stable(r.secs)) // RULE21
    else $error("timer advanced while paused");
  secs_cleared_a: assert property (tmr.clear |=> r.secs == '0 ##1 !r.fast_exp) // RULE16
    else $error("timer not cleared");
endmodule

// ==== hdl/lcc_tmr_if.sv ====
// Purpose: Link between the sequencer and its safety timer
// Assumes: Both ends on core_clk_in
// Notes: Control signals are combinational from the sequencer state
interface lcc_tmr_if import lcc_pkg::*; ();
  logic clear;
  logic run;
  logic half;
  logic pre_exp;
  logic fast_exp;
  logic boost;
  logic [SEC_W-1:0] secs;
  modport ctrl (output clear, run, half, input pre_exp, fast_exp, boost, secs);
  modport timer (input clear, run, half, output pre_exp, fast_exp, boost, secs);
endinterface

// ==== testbench/lcc_batt_model.sv ====
// Purpose: Battery pack with thermistor as the charger pins see it
// Assumes: Zone 0 freezing, 1 cold, 2 normal, 3 warm, 4 hot
// Notes: Ideal comparators, no hysteresis or deglitch
module lcc_batt_model (
  input wire logic [2:0] zone_in, // Thermistor zone
  input wire logic fitted_in, // Pack inserted
  output logic below0_out, // Below 0 C
  output logic below10_out, // Below 10 C
  output logic above45_out, // Above 45 C
  output logic above60_out, // Above 60 C
  output logic present_out // Detect result
);
  // Zone to comparator levels; adjacent zones share edges
  assign below0_out = (zone_in == 3'h0);
  assign below10_out = (zone_in <= 3'h1);
  assign above45_out = (zone_in >= 3'h3);
  assign above60_out = (zone_in == 3'h4);
  assign present_out = fitted_in;
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the charge sequencer
// Assumes: Shortened timers, tick of TK cycles
// Notes: Pins settle through a 2-flop sync, so checks wait a few edges
module testbench import lcc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 16;
  logic clk = 1'b0, rst = 1'b1, uvlo = 1'b0, igo = 1'b0, ovp = 1'b0, fold = 1'b0;
  logic therm = 1'b0, shrt = 1'b0, c50 = 1'b0, lowv = 1'b0, rch = 1'b0, term = 1'b0;
  logic tsl = 1'b0, tsh = 1'b0, popen = 1'b1, fit = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [6:0] pct = 7'h0A;
  logic [2:0] zone = 3'h2;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, rdat;
  logic b0, b10, a45, a60, bp, ack, charge_indicator_output, qual, half, fl, tl, oe, pg, hiz, det, bst;
  logic [12:0] vreg;
  logic [6:0] tp;
  logic [7:0] pp;
  logic [3:0] ph;
  int miscompares = 0, comparisons = 0, cnt;
  lcc_batt_model u_lcc_batt_model (.zone_in(zone), .fitted_in(fit), .below0_out(b0),
    .below10_out(b10), .above45_out(a45), .above60_out(a60), .present_out(bp));
  lcc_ctrl #(.TICK_CYC_P(32'(TK)), .PRE_S_P(17'h3), .FAST_S_P(17'h64), .BOOST_S_P(17'h2))
  u_lcc_ctrl (.core_clk_in(clk), .rst_in(rst), .uvlo_ok_in(uvlo), .in_gt_out_in(igo),
    .ovp_in(ovp), .input_voltage_foldback_in(fold), .thermal_reg_in(therm),
    .fast_current_program_pin_short_in(shrt), .cur_ge_50_in(c50), .lowv_ok_in(lowv), .above_rch_in(rch),
    .at_term_in(term), .batt_present_in(bp), .ts_low_in(tsl), .ts_high_in(tsh),
    .below0_in(b0), .below10_in(b10), .above45_in(a45), .above60_in(a60),
    .preterm_open_in(popen), .preterm_pct_in(pct), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_dat_o(rdat), .charge_en_out(charge_indicator_output), .qual_charge_out(qual), .halve_current_out(half),
    .vreg_limit_mv_out(vreg), .term_pct_out(tp), .pre_pct_out(pp), .foldback_limit_out(fl),
    .thermal_limit_out(tl), .charge_indicator_output_oe_out(oe), .power_good_out(pg),
    .hiz_out(hiz), .batt_detect_out(det), .term_boost_out(bst), .phase_out(ph));
  // Free-running core clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Classic cycle; ack and read data taken at the rising edge that sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cnt = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      cnt++;
    end while (ack !== 1'b1 && cnt < 50);
    rd = rdat;
    chk("wb_ack", 1, ack);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Bounded wait for a phase, then one more edge for the outputs
  task automatic await(input logic [3:0] p, input int lim);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (ph !== p && cnt < lim);
    @(posedge clk);
    @(negedge clk);
    chk("phase", p, ph);
  endtask
  function automatic logic [12:0] exp_vreg(input logic [2:0] z);
    return (z == 3'h3) ? WARM_VREG_STD_MV : VREG_FULL;
  endfunction
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard, well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(76));
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk("hiz", 1, hiz);
    @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    wb(1'b1, ADDR_STAT, 32'hFFFF_FFFF);
    wb(1'b0, ADDR_STAT, 32'h0);
    chk("stat", 32'h0, rd);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test registers done");
    @(posedge clk);
    uvlo <= 1'b1;
    igo <= 1'b1;
    await(ST_QUAL, 20);
    chk("qual", 1, qual);
    chk("pg", 1, pg);
    chk("boost", 1, bst);
    chk("term", 10, tp);
    chk("pre", 20, pp);
    await(ST_PRE, 2100);
    await(ST_TIMEOUT, 200);
    chk("pre_time", 1, cnt >= 2 * TK && cnt <= 3 * TK + 8);
    // Indicator drops one edge after the first-charge flag clears
    repeat (2) @(negedge clk);
    chk("chg_en", 0, charge_indicator_output);
    chk("ind", 0, oe);
    wb(1'b0, ADDR_TIME, 32'h0);
    chk("time", 3, rd);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      popen <= 1'b0;
      pct <= 7'($urandom_range(50, 5));
      repeat (6) @(negedge clk);
      chk("pre", {pct, 1'b0}, pp);
      chk("term", pct, tp);
    end
    $display("test precharge timeout done");
    @(posedge clk);
    tsl <= 1'b1;
    lowv <= 1'b1;
    await(ST_DISABLED, 20);
    @(posedge clk);
    tsl <= 1'b0;
    await(ST_QUAL, 20);
    await(ST_FAST, 2100);
    for (int z = 0; z < 5; z++) begin
      @(posedge clk);
      zone <= 3'(z);
      repeat (6) @(negedge clk);
      chk("half", z == 1, half);
      chk("vreg", exp_vreg(3'(z)), vreg);
      chk("chg_en", z >= 1 && z <= 3, charge_indicator_output);
    end
    @(posedge clk);
    zone <= 3'h2;
    fold <= 1'b1;
    therm <= 1'b1;
    repeat (6) @(negedge clk);
    chk("fold", 1, fl);
    chk("therm", 1, tl);
    $display("test zones done");
    wb(1'b1, ADDR_CTRL, 32'h1);
    await(ST_DISABLED, 20);
    chk("chg_en", 0, charge_indicator_output);
    wb(1'b1, ADDR_CTRL, 32'h0);
    await(ST_QUAL, 20);
    @(posedge clk);
    fold <= 1'b0;
    therm <= 1'b0;
    await(ST_FAST, 2100);
    @(posedge clk);
    rch <= 1'b1;
    fit <= 1'b0;
    await(ST_CV, 20);
    @(posedge clk);
    term <= 1'b1;
    await(ST_DETECT, 20);
    chk("detect", 1, det);
    repeat (1500) @(negedge clk);
    chk("phase", ST_DETECT, ph);
    @(posedge clk);
    fit <= 1'b1;
    // Next detect verdict lands up to one settle window later
    await(ST_QUAL, 600);
    await(ST_DONE, 3500);
    chk("chg_en", 0, charge_indicator_output);
    @(posedge clk);
    rch <= 1'b0;
    term <= 1'b0;
    await(ST_QUAL, 20);
    $display("test termination done");
    @(posedge clk);
    igo <= 1'b0;
    await(ST_SLEEP, 20);
    chk("chg_en", 0, charge_indicator_output);
    @(posedge clk);
    igo <= 1'b1;
    c50 <= 1'b1;
    shrt <= 1'b1;
    await(ST_SHORT, 40);
    chk("chg_en", 0, charge_indicator_output);
    @(posedge clk);
    uvlo <= 1'b0;
    repeat (6) @(negedge clk);
    chk("hiz", 1, hiz);
    $display("test sleep short lockout done");
    summarize();
  end
endmodule
